// file: design/iox_expander.sv
// Operation
// - sixteen lines in two eight-line ports, each individually input or output
// - two 8-bit configuration registers hold direction bits written by the master
// - input register shows sampled pin levels; outputs driven from output register
// - polarity bit set inverts the value read back for that input
// - every register, not only inputs, can be read by the master
// - interrupt asserted low while any input differs from its stored state
// - reset loads register defaults and returns serial state machine to idle
// - three address-select pins set low slave address bits, eight devices per bus
// - serial clock and data inputs filtered before the bus logic sees them
// - works from zero up to 400 kHz serial clock; bus may stop indefinitely
// - glitches up to 50 ns on clock and data are not taken as edges
`timescale 1ns/1ps
module iox_expander
	import iox_pkg::*;
#(
	parameter logic [3:0] FIXED_ADDR = IOX_FIXED_ADDR,
	parameter int         FILT_CYC   = IOX_FILT_CYC
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic [2:0]  addr_select_i,
	input  wire logic [15:0] io_i,
	output logic [15:0]      io_o,
	output logic [15:0]      io_oe_o,
	output logic             int_n_o,
	output logic             int_n_oe_o
);

	iox_serial_t line_f;
	logic        scl_f;
	logic        sda_f;
	iox_serial_t line_q;
	iox_regs_t   regs;
	iox_state_t  state;

	logic [15:0] io_s1;
	logic [15:0] io_s;
	logic [2:0]  adr_s1;
	logic [2:0]  adr_s;
	logic [15:0] in_last;
	logic [7:0]  shift;
	logic [7:0]  txsh;
	logic [2:0]  bitcnt;
	logic [2:0]  cmd;
	logic        byte_done;
	logic        ack_ok;
	logic        drv_low;
	logic        int_act;

	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	logic        wr_stb;
	logic        rd_load;
	logic        addr_hit;
	logic [15:0] in_view;
	logic [7:0]  rd_byte;

	iox_glitch_filter #(.STABLE(FILT_CYC)) u_scl_filt (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.line_i (scl_i),
		.line_o (scl_f)
	);

	iox_glitch_filter #(.STABLE(FILT_CYC)) u_sda_filt (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.line_i (sda_i),
		.line_o (sda_f)
	);

	assign line_f = '{scl: scl_f, sda: sda_f};

	// pin synchronisers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			io_s1  <= '0;
			io_s   <= '0;
			adr_s1 <= '0;
			adr_s  <= '0;
		end
		else
		begin
			io_s1  <= io_i;
			io_s   <= io_s1;
			adr_s1 <= addr_select_i;
			adr_s  <= adr_s1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			line_q <= '{scl: 1'b1, sda: 1'b1};
		else
			line_q <= line_f;
	end

	// edges found by sampling, so any slow or stopped clock works
	assign scl_rise = line_f.scl & ~line_q.scl;
	assign scl_fall = ~line_f.scl & line_q.scl;
	assign start_c  = line_f.scl & line_q.scl & line_q.sda & ~line_f.sda;
	assign stop_c   = line_f.scl & line_q.scl & ~line_q.sda & line_f.sda;

	// address compare with the select pins
	assign addr_hit = (shift[7:1] == {FIXED_ADDR, adr_s});

	// polarity inversion on the read value
	assign in_view = io_s ^ regs.pol;
	assign rd_byte = reg_byte(cmd, in_view, regs);

	assign wr_stb  = (state == ST_WR) & scl_fall & byte_done;
	assign rd_load = scl_fall & ((state == ST_ACK_ADDR & shift[0]) | (state == ST_RD_ACK & ack_ok));

	function automatic logic [7:0] reg_byte(input logic [2:0] idx, input logic [15:0] inv, input iox_regs_t r);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			IOX_REG_IN_LO:  b = inv[7:0];
			IOX_REG_IN_HI:  b = inv[15:8];
			IOX_REG_OUT_LO: b = r.out[7:0];
			IOX_REG_OUT_HI: b = r.out[15:8];
			IOX_REG_POL_LO: b = r.pol[7:0];
			IOX_REG_POL_HI: b = r.pol[15:8];
			IOX_REG_CFG_LO: b = r.cfg[7:0];
			IOX_REG_CFG_HI: b = r.cfg[15:8];
			default:        b = 8'h00;
		endcase
		return b;
	endfunction : reg_byte

	// serial bus state machine
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state     <= ST_IDLE;
			shift     <= '0;
			txsh      <= '0;
			bitcnt    <= '0;
			byte_done <= 1'b0;
			ack_ok    <= 1'b0;
			drv_low   <= 1'b0;
			cmd       <= '0;
		end
		else if (start_c)
		begin
			state     <= ST_ADDR;
			bitcnt    <= '0;
			byte_done <= 1'b0;
			drv_low   <= 1'b0;
		end
		else if (stop_c)
		begin
			state   <= ST_IDLE;
			drv_low <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
					drv_low <= 1'b0;
				ST_ADDR, ST_CMD, ST_WR:
				begin
					if (scl_rise)
					begin
						shift     <= {shift[6:0], line_f.sda};
						bitcnt    <= bitcnt + 3'h1;
						byte_done <= (bitcnt == 3'h7);
					end
					else if (scl_fall & byte_done)
					begin
						byte_done <= 1'b0;
						if (state == ST_ADDR)
						begin
							state   <= addr_hit ? ST_ACK_ADDR : ST_IDLE;
							drv_low <= addr_hit;
						end
						else if (state == ST_CMD)
						begin
							cmd     <= shift[2:0];
							state   <= ST_ACK_CMD;
							drv_low <= 1'b1;
						end
						else
						begin
							cmd     <= {cmd[2:1], ~cmd[0]};
							state   <= ST_ACK_WR;
							drv_low <= 1'b1;
						end
					end
				end
				ST_ACK_ADDR:
				begin
					if (scl_fall)
					begin
						bitcnt <= '0;
						if (shift[0])
						begin
							txsh    <= rd_byte;
							drv_low <= ~rd_byte[7];
							cmd     <= {cmd[2:1], ~cmd[0]};
							state   <= ST_RD;
						end
						else
						begin
							drv_low <= 1'b0;
							state   <= ST_CMD;
						end
					end
				end
				ST_ACK_CMD, ST_ACK_WR:
				begin
					if (scl_fall)
					begin
						drv_low <= 1'b0;
						bitcnt  <= '0;
						state   <= ST_WR;
					end
				end
				ST_RD:
				begin
					if (scl_rise)
					begin
						bitcnt    <= bitcnt + 3'h1;
						byte_done <= (bitcnt == 3'h7);
					end
					else if (scl_fall)
					begin
						if (byte_done)
						begin
							byte_done <= 1'b0;
							drv_low   <= 1'b0;
							state     <= ST_RD_ACK;
						end
						else
						begin
							txsh    <= {txsh[6:0], 1'b0};
							drv_low <= ~txsh[6];
						end
					end
				end
				ST_RD_ACK:
				begin
					if (scl_rise)
					begin
						ack_ok <= ~line_f.sda;
						if (line_f.sda)
							state <= ST_IDLE;
					end
					else if (scl_fall & ack_ok)
					begin
						txsh    <= rd_byte;
						drv_low <= ~rd_byte[7];
						cmd     <= {cmd[2:1], ~cmd[0]};
						bitcnt  <= '0;
						ack_ok  <= 1'b0;
						state   <= ST_RD;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// register writes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			regs.out <= IOX_OUT_RESET;
			regs.pol <= IOX_POL_RESET;
			regs.cfg <= IOX_CFG_RESET;
		end
		else if (wr_stb)
		begin
			case (cmd)
				IOX_REG_OUT_LO: regs.out[7:0]  <= shift;
				IOX_REG_OUT_HI: regs.out[15:8] <= shift;
				IOX_REG_POL_LO: regs.pol[7:0]  <= shift;
				IOX_REG_POL_HI: regs.pol[15:8] <= shift;
				IOX_REG_CFG_LO: regs.cfg[7:0]  <= shift;
				IOX_REG_CFG_HI: regs.cfg[15:8] <= shift;
				default:        regs.cfg       <= regs.cfg;
			endcase
		end
	end

	// input state stored at each read of an input register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			in_last <= io_s;
		else if (rd_load & (cmd == IOX_REG_IN_LO))
			in_last[7:0] <= io_s[7:0];
		else if (rd_load & (cmd == IOX_REG_IN_HI))
			in_last[15:8] <= io_s[15:8];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			int_act <= 1'b0;
		else
			int_act <= |(regs.cfg & (io_s ^ in_last));
	end

	assign io_o       = regs.out;
	// per-line direction, config bit set means input
	assign io_oe_o    = ~regs.cfg;
	assign int_n_o    = 1'b0;
	assign int_n_oe_o = int_act;
	assign sda_o      = 1'b0;
	assign sda_oe_o   = drv_low;

endmodule : iox_expander

// file: design/iox_glitch_filter.sv
`timescale 1ns/1ps
module iox_glitch_filter
	import iox_pkg::*;
#(
	parameter int STABLE = IOX_FILT_CYC
)
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic line_i,
	output logic      line_o
);
	localparam int CW = $clog2(STABLE + 1) + 1;

	logic          sync1;
	logic          sync2;
	logic [CW-1:0] cnt;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
		end
		else
		begin
			sync1 <= line_i;
			sync2 <= sync1;
		end
	end

	// a level must stand longer than the spike time before it passes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt    <= '0;
			line_o <= 1'b1;
		end
		else if (sync2 == line_o)
			cnt <= '0;
		else if (cnt == CW'(STABLE))
		begin
			line_o <= sync2;
			cnt    <= '0;
		end
		else
			cnt <= cnt + CW'(1);
	end

endmodule : iox_glitch_filter

// file: design/iox_pkg.sv
package iox_pkg;

	// command byte indices of the eight byte registers
	localparam logic [2:0] IOX_REG_IN_LO  = 3'h0;
	localparam logic [2:0] IOX_REG_IN_HI  = 3'h1;
	localparam logic [2:0] IOX_REG_OUT_LO = 3'h2;
	localparam logic [2:0] IOX_REG_OUT_HI = 3'h3;
	localparam logic [2:0] IOX_REG_POL_LO = 3'h4;
	localparam logic [2:0] IOX_REG_POL_HI = 3'h5;
	localparam logic [2:0] IOX_REG_CFG_LO = 3'h6;
	localparam logic [2:0] IOX_REG_CFG_HI = 3'h7;

	// reset values
	localparam logic [15:0] IOX_OUT_RESET = 16'hFFFF;
	localparam logic [15:0] IOX_POL_RESET = 16'h0000;
	localparam logic [15:0] IOX_CFG_RESET = 16'hFFFF;

	// fixed upper slave address bits, value arbitrary
	localparam logic [3:0] IOX_FIXED_ADDR = 4'h2;

	// spike suppression time and its cycle count at the system clock
	localparam int IOX_CLK_MHZ  = 40;
	localparam int IOX_SPIKE_NS = 50;
	localparam int IOX_FILT_CYC = (IOX_SPIKE_NS * IOX_CLK_MHZ + 999) / 1000;

	localparam int IOX_PORT_W = 8;
	localparam int IOX_LINES  = 16;

	typedef struct packed {
		logic [15:0] out;
		logic [15:0] pol;
		logic [15:0] cfg;
	} iox_regs_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} iox_serial_t;

	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_CMD,
		ST_ACK_CMD,
		ST_WR,
		ST_ACK_WR,
		ST_RD,
		ST_RD_ACK
	} iox_state_t;

endpackage : iox_pkg

// file: sim/iox_expander_properties.sv
`timescale 1ns/1ps
module iox_props
	import iox_pkg::*;
(
	input logic        clk_i,
	input logic        rst_i,
	input logic        scl_i,
	input logic        sda_o,
	input logic        sda_oe_o,
	input logic [15:0] io_i,
	input logic [15:0] io_o,
	input logic [15:0] io_oe_o,
	input logic        int_n_o,
	input logic        int_n_oe_o
);
	logic [4:0] sq;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_hi;
		scl_i [*8];
	endsequence
	always_ff @(posedge clk_i)
	begin
		if (rst_i || $changed(scl_i))
			sq <= 5'h00;
		else if (sq != 5'h1F)
			sq <= sq + 5'h01;
	end
	a_od_low: assert property (!sda_o && !int_n_o)
		else $error("open drain level");
	a_reset_vals: assert property ($fell(rst_i) |-> io_o == IOX_OUT_RESET && !io_oe_o && !int_n_oe_o)
		else $error("reset values");
	a_io_late: assert property ($changed(io_o) |-> !scl_i && sq > 5'h02 && sq < 5'h10)
		else $error("output timing");
	a_oe_late: assert property ($changed(io_oe_o) |-> !scl_i && sq > 5'h02 && sq < 5'h10)
		else $error("direction timing");
	a_sda_late: assert property ($changed(sda_oe_o) |-> !scl_i && sq > 5'h02 && sq < 5'h10)
		else $error("data timing");
	a_sda_stands: assert property (s_hi |-> $stable(sda_oe_o))
		else $error("data moved in clock high");
	a_int_cause: assert property ($rose(int_n_oe_o) |-> io_i != $past(io_i, 8))
		else $error("interrupt without change");
	a_int_clear: assert property ($fell(int_n_oe_o) |-> io_i != $past(io_i, 8) || sq < 5'h10)
		else $error("interrupt release without cause");
endmodule : iox_props
bind iox_expander iox_props u_iox_props (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o), .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o));

// file: sim/iox_master.sv
`timescale 1ns/1ps
module iox_master
(
	input  logic clk_i,
	input  logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	int hp = 50;
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic w(input int k);
		repeat (k) @(posedge clk_i);
	endtask : w
	task automatic start();
		sda_low_o <= 1'b0;
		w(hp);
		scl_o <= 1'b1;
		w(hp);
		sda_low_o <= 1'b1;
		w(hp);
		scl_o <= 1'b0;
		w(hp);
	endtask : start
	task automatic stop();
		sda_low_o <= 1'b1;
		w(hp);
		scl_o <= 1'b1;
		w(hp);
		sda_low_o <= 1'b0;
		w(hp);
	endtask : stop
	task automatic bt(input logic b, output logic r);
		sda_low_o <= ~b;
		w(hp);
		scl_o <= 1'b1;
		w(hp);
		r = sda_i;
		scl_o <= 1'b0;
		w(hp / 2);
	endtask : bt
	task automatic xb(input logic [7:0] d, input logic l, output logic [7:0] q, output logic nak);
		for (int i = 7; i >= 0; i--)
			bt(d[i], q[i]);
		bt(l, nak);
	endtask : xb
endmodule : iox_master

// file: sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(n,e,a) begin compares++;if((a)!==(e))begin failures++;$display("[ERR] %s exp %h got %h",n,e,a);end end
module tb_top;
	import iox_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        glt   = 1'b0;
	logic        m_scl;
	logic        m_low;
	logic        sda_oe_o;
	logic        int_n_oe_o;
	logic        n;
	logic [2:0]  sel   = 3'h5;
	logic [7:0]  q;
	logic [15:0] pins  = 16'h0000;
	logic [15:0] v;
	logic [15:0] io_o;
	logic [15:0] io_oe_o;
	int          failures = 0;
	int          compares = 0;
	int          cyc = 0;
	always #12.5 clk_i = ~clk_i;
	iox_master u_iox_master (.clk_i(clk_i), .sda_i(~(m_low | sda_oe_o)), .scl_o(m_scl), .sda_low_o(m_low));
	iox_expander u_iox_expander (.clk_i(clk_i), .rst_i(rst_i), .scl_i(m_scl & ~glt),
		.sda_i(~(m_low | sda_oe_o)), .sda_o(), .sda_oe_o(sda_oe_o), .addr_select_i(sel),
		.io_i((io_oe_o & io_o) | (~io_oe_o & pins)), .io_o(io_o), .io_oe_o(io_oe_o), .int_n_o(),
		.int_n_oe_o(int_n_oe_o));
	task automatic end_sim();
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic tx(input logic [7:0] d);
		u_iox_master.xb(d, 1'b1, q, n);
		`CHK("ack", 1'b0, n)
	endtask : tx
	task automatic hd(input logic [2:0] c);
		u_iox_master.start();
		tx({IOX_FIXED_ADDR, sel, 1'b0});
		tx({5'h00, c});
	endtask : hd
	task automatic wr(input logic [2:0] c, input logic [15:0] d);
		hd(c);
		tx(d[7:0]);
		tx(d[15:8]);
		u_iox_master.stop();
	endtask : wr
	task automatic rd(input logic [2:0] c);
		hd(c);
		u_iox_master.start();
		tx({IOX_FIXED_ADDR, sel, 1'b1});
		u_iox_master.xb(8'hFF, 1'b0, v[7:0], n);
		u_iox_master.xb(8'hFF, 1'b1, v[15:8], n);
		u_iox_master.stop();
	endtask : rd
	task automatic pin(input logic [15:0] m, input logic e);
		pins <= pins ^ m;
		repeat (12) @(posedge clk_i);
		`CHK("int", e, int_n_oe_o)
	endtask : pin
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc > 90000)
		begin
			failures++;
			end_sim();
		end
	end
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(IOX_REG_OUT_LO);
		`CHK("out", IOX_OUT_RESET, v)
		rd(IOX_REG_CFG_LO);
		`CHK("cfg", IOX_CFG_RESET, v)
		pins <= 16'h3C96;
		wr(IOX_REG_OUT_LO, 16'hA55A);
		wr(IOX_REG_CFG_LO, 16'h0FF0);
		wr(IOX_REG_POL_LO, 16'hFF00);
		`CHK("io_o", 16'hA55A, io_o)
		`CHK("io_oe_o", 16'hF00F, io_oe_o)
		rd(IOX_REG_CFG_LO);
		`CHK("cfg", 16'h0FF0, v)
		rd(IOX_REG_IN_LO);
		`CHK("in", (16'hA00A | 16'h0C90) ^ 16'hFF00, v)
		pin(16'h0000, 1'b0);
		pin(16'h0010, 1'b1);
		pin(16'h0010, 1'b0);
		pin(16'h0101, 1'b1);
		rd(IOX_REG_IN_LO);
		pin(16'h0000, 1'b0);
		fork
			wr(IOX_REG_OUT_LO, 16'h1234);
			begin
				repeat (270) @(posedge clk_i);
				glt <= 1'b1;
				repeat (2) @(posedge clk_i);
				glt <= 1'b0;
			end
		join
		`CHK("io_o", 16'h1234, io_o)
		pin(16'h0000, 1'b0);
		u_iox_master.hp = 70;
		for (int s = 0; s < 9; s++)
		begin
			sel <= s[2:0];
			u_iox_master.start();
			u_iox_master.xb({IOX_FIXED_ADDR, (s > 7) ? 3'h7 : s[2:0], 1'b0}, 1'b1, q, n);
			u_iox_master.stop();
			`CHK("addr", s > 7, n)
		end
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK("io_o", IOX_OUT_RESET, io_o)
		`CHK("io_oe_o", 16'h0000, io_oe_o)
		end_sim();
	end
endmodule : tb_top
